// ===== shared/psb_pkg.sv
// Constants, types and helpers shared by the adapter-end sideband design.
// Assumes one 25 MHz system clock; all pin levels are active low unless named otherwise.
package psb_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 25;
  localparam int TIMEOUT_US = 10;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int TMR_W = 9;
  localparam logic [TMR_W-1:0] TIMEOUT_LOAD = TMR_W'(TIMEOUT_CYC);

  // ****************************************
  // Widths and levels
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int PRIO_W = 4;
  localparam int GRANT_W = 4;
  localparam logic PIN_ASSERT = 1'b0;
  localparam logic PIN_NEGATE = 1'b1;

  // Adapter space starts here; a plain default for the address map
  localparam logic [ADDR_W-1:0] ADAPTER_MEM_BASE = 16'hC000;
  // Priorities that own a backplane grant line
  localparam logic [PRIO_W-1:0] PRIO_GRANT_LOW = 4'h4;
  localparam logic [PRIO_W-1:0] PRIO_GRANT_TOP = 4'h7;
  localparam logic [GRANT_W-1:0] GRANT_ONE = 4'h1;

  // ****************************************
  // Cycle kinds, coded as {write_indicator, byte_select} pin levels
  // ****************************************
  typedef enum logic [1:0] {
    CYC_BYTE_WRITE = 2'h0,
    CYC_WORD_WRITE = 2'h1,
    CYC_RMW_READ = 2'h2,
    CYC_READ = 2'h3
  } psb_cycle_e;

  // ****************************************
  // Controller states, Gray along the usual paths except ST_SLV_END and ST_INT_END back to ST_IDLE and the ST_INT_GRANT timeout to ST_INT_END
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SLV_WAIT = 4'h1,
    ST_SLV_END = 4'h3,
    ST_INT_PRIO = 4'h2,
    ST_INT_GRANT = 4'h6,
    ST_INT_VEC = 4'h7,
    ST_INT_END = 4'h5,
    ST_MST_OWN = 4'h4,
    ST_MST_CYC = 4'hC
  } psb_state_e;

  // Address falls in the adapter's memory space
  function automatic logic in_adapter_space(input logic [ADDR_W-1:0] a);
    return a >= ADAPTER_MEM_BASE;
  endfunction : in_adapter_space

  // One-hot backplane grant for a priority; zero when no line owns it
  function automatic logic [GRANT_W-1:0] grant_for(input logic [PRIO_W-1:0] p);
    logic [PRIO_W-1:0] idx;
    idx = p - PRIO_GRANT_LOW;
    if (p >= PRIO_GRANT_LOW && p <= PRIO_GRANT_TOP) begin
      return GRANT_ONE << idx[1:0];
    end
    return '0;
  endfunction : grant_for

endpackage : psb_pkg

// ===== hw/psb_timer.sv
// One-shot timeout counter used for both the slave and interrupt timeouts.
// Assumes start and stop are single-cycle requests from the controller.
`timescale 1ns/1ps

module psb_timer (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic stop,
  output logic expired,
  output logic running
);

  // ****************************************
  // Countdown
  // ****************************************
  logic [psb_pkg::TMR_W-1:0] count;

  // Start reloads even while running, so a restart never inherits old time
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (start) begin
        count <= psb_pkg::TIMEOUT_LOAD;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running) begin
        if (count == psb_pkg::TMR_W'(1)) begin
          running <= 1'b0;
          expired <= 1'b1;
        end
        count <= count - psb_pkg::TMR_W'(1);
      end
    end
  end

endmodule : psb_timer

// ===== hw/psb_adapter_end.sv
// Adapter end of the private memory link sideband: slave replies, interrupt grant, mastership.
// Assumes the CPU end keeps its own duties and all pins are synchronous to clk_sys.
`timescale 1ns/1ps

module psb_adapter_end (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic map_enable_out_n,
  input wire logic cycle_frame_in_n,
  output logic cycle_frame_out_n,
  output logic cycle_frame_oe,
  input wire logic write_indicator_in_n,
  output logic write_indicator_out_n,
  output logic write_indicator_oe,
  input wire logic byte_select_in_n,
  output logic byte_select_out_n,
  output logic byte_select_oe,
  input wire logic interconnect_busy_in_n,
  output logic interconnect_busy_out_n,
  output logic interconnect_busy_oe,
  output logic reply_line_out_n,
  output logic reply_line_oe,
  input wire logic [psb_pkg::ADDR_W-1:0] multiplexed_addr_data_in,
  input wire logic data_input_strobe_n,
  input wire logic interrupt_ack_in_n,
  input wire logic line_power_low_n,
  output logic map_enabled,
  output logic adapter_system_present_n,
  output logic adapter_memory_space_n,
  output logic adapter_timeout_n,
  output logic power_good_line,
  output logic [psb_pkg::GRANT_W-1:0] bus_grant,
  output logic [psb_pkg::PRIO_W-1:0] int_priority,
  output logic bk_req,
  output logic [psb_pkg::ADDR_W-1:0] bk_addr,
  output psb_pkg::psb_cycle_e bk_kind,
  input wire logic bk_done,
  input wire logic bk_select_ack,
  input wire logic bk_vector_done,
  input wire logic mst_request,
  output logic mst_granted,
  input wire logic mst_start,
  input wire psb_pkg::psb_cycle_e mst_kind,
  input wire logic mst_end
);

  // ****************************************
  // Declarations
  // ****************************************
  psb_pkg::psb_state_e state;
  psb_pkg::psb_state_e next_state;
  psb_pkg::psb_cycle_e drive_kind;
  logic frame_prev;
  logic strobe_prev;
  logic frame_fall;
  logic strobe_fall;
  logic slave_take;
  logic tmo;
  logic tmr_start;
  logic tmr_stop;
  logic tmr_expired;
  logic tmr_running;

  // Edges seen on the CPU's frame and data-input strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_prev <= psb_pkg::PIN_NEGATE;
      strobe_prev <= psb_pkg::PIN_NEGATE;
    end else begin
      frame_prev <= cycle_frame_in_n;
      strobe_prev <= data_input_strobe_n;
    end
  end

  assign frame_fall = frame_prev && !cycle_frame_in_n;
  assign strobe_fall = strobe_prev && !data_input_strobe_n;
  // Claim only cycles whose adapter-space flag stood when the frame came
  assign slave_take = (state == psb_pkg::ST_IDLE) && frame_fall && !adapter_memory_space_n;

  // ****************************************
  // Control state machine
  // ****************************************
  always_comb begin
    next_state = state;
    unique case (state)
      psb_pkg::ST_IDLE: begin
        if (slave_take) begin
          next_state = psb_pkg::ST_SLV_WAIT;
        end else if (strobe_fall) begin
          next_state = psb_pkg::ST_INT_PRIO;
        end else if (mst_request && interconnect_busy_in_n && cycle_frame_in_n) begin
          next_state = psb_pkg::ST_MST_OWN;
        end
      end
      psb_pkg::ST_SLV_WAIT: begin
        if (bk_done || tmr_expired) begin
          next_state = psb_pkg::ST_SLV_END;
        end
      end
      psb_pkg::ST_SLV_END: begin
        if (cycle_frame_in_n) begin
          next_state = psb_pkg::ST_IDLE;
        end
      end
      psb_pkg::ST_INT_PRIO: begin
        if (!interrupt_ack_in_n) begin
          next_state = psb_pkg::ST_INT_GRANT;
        end
      end
      psb_pkg::ST_INT_GRANT: begin
        if (bk_select_ack) begin
          next_state = psb_pkg::ST_INT_VEC;
        end else if (tmr_expired) begin
          next_state = psb_pkg::ST_INT_END;
        end
      end
      psb_pkg::ST_INT_VEC: begin
        if (bk_vector_done || tmr_expired) begin
          next_state = psb_pkg::ST_INT_END;
        end
      end
      psb_pkg::ST_INT_END: begin
        if (interrupt_ack_in_n) begin
          next_state = psb_pkg::ST_IDLE;
        end
      end
      psb_pkg::ST_MST_OWN: begin
        if (mst_start) begin
          next_state = psb_pkg::ST_MST_CYC;
        end else if (!mst_request) begin
          next_state = psb_pkg::ST_IDLE;
        end
      end
      psb_pkg::ST_MST_CYC: begin
        if (mst_end) begin
          next_state = psb_pkg::ST_MST_OWN;
        end
      end
      default: begin
        next_state = psb_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= psb_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Timeouts
  // ****************************************
  // One timer serves both: slave and interrupt waits never overlap
  assign tmr_start = slave_take
                     || (state == psb_pkg::ST_INT_PRIO && !interrupt_ack_in_n)
                     || (state == psb_pkg::ST_INT_GRANT && bk_select_ack);
  assign tmr_stop = (state == psb_pkg::ST_SLV_WAIT && bk_done)
                    || (state == psb_pkg::ST_INT_VEC && bk_vector_done);

  psb_timer u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(tmr_start),
    .stop(tmr_stop),
    .expired(tmr_expired),
    .running(tmr_running)
  );

  // Timeout stays up until the CPU closes the frame or drops its acknowledge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tmo <= 1'b0;
    end else if (tmr_expired && !(state == psb_pkg::ST_SLV_WAIT && bk_done) && state != psb_pkg::ST_IDLE) begin
      tmo <= 1'b1;
    end else if (next_state == psb_pkg::ST_IDLE) begin
      tmo <= 1'b0;
    end
  end

  assign adapter_timeout_n = !tmo;

  // ****************************************
  // Slave side of CPU cycles
  // ****************************************
  // Space flag tracks the address between cycles, held through a claimed one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adapter_memory_space_n <= psb_pkg::PIN_NEGATE;
    end else if (state == psb_pkg::ST_IDLE && cycle_frame_in_n) begin
      adapter_memory_space_n <= !psb_pkg::in_adapter_space(multiplexed_addr_data_in);
    end else if (state == psb_pkg::ST_IDLE && !slave_take) begin
      adapter_memory_space_n <= psb_pkg::PIN_NEGATE;
    end
  end

  // Hand the claimed cycle to the backplane side, typed from the pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bk_req <= 1'b0;
      bk_addr <= '0;
      bk_kind <= psb_pkg::CYC_READ;
    end else begin
      bk_req <= slave_take;
      if (slave_take) begin
        bk_addr <= multiplexed_addr_data_in;
        bk_kind <= psb_pkg::psb_cycle_e'({write_indicator_in_n, byte_select_in_n});
      end
    end
  end

  // Reply holds off the next master until the CPU ends the frame; byte writes included
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reply_line_oe <= 1'b0;
    end else if (state == psb_pkg::ST_SLV_WAIT && bk_done) begin
      reply_line_oe <= 1'b1;
    end else if (state == psb_pkg::ST_SLV_END && cycle_frame_in_n) begin
      reply_line_oe <= 1'b0;
    end
  end

  assign reply_line_out_n = psb_pkg::PIN_ASSERT;

  // ****************************************
  // Interrupt grant
  // ****************************************
  // Priority is taken on the strobe's leading edge, not its level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_priority <= '0;
    end else if (state == psb_pkg::ST_IDLE && strobe_fall) begin
      int_priority <= multiplexed_addr_data_in[psb_pkg::PRIO_W-1:0];
    end
  end

  // A priority with no grant line simply runs into the timeout
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_grant <= '0;
    end else if (state == psb_pkg::ST_INT_PRIO && !interrupt_ack_in_n) begin
      bus_grant <= psb_pkg::grant_for(int_priority);
    end else if (state != psb_pkg::ST_INT_GRANT) begin
      bus_grant <= '0;
    end
  end

  // ****************************************
  // Link mastership and own cycles
  // ****************************************
  assign mst_granted = (state == psb_pkg::ST_MST_OWN) || (state == psb_pkg::ST_MST_CYC);
  assign interconnect_busy_oe = mst_granted;
  assign interconnect_busy_out_n = psb_pkg::PIN_ASSERT;
  assign cycle_frame_oe = (state == psb_pkg::ST_MST_CYC);
  assign cycle_frame_out_n = psb_pkg::PIN_ASSERT;
  assign write_indicator_oe = mst_granted;
  assign byte_select_oe = mst_granted;

  // Kind is latched at start so the pins stay steady for the whole cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drive_kind <= psb_pkg::CYC_READ;
    end else if (state == psb_pkg::ST_MST_OWN && mst_start) begin
      drive_kind <= mst_kind;
    end
  end

  assign write_indicator_out_n = drive_kind[1];
  assign byte_select_out_n = drive_kind[0];

  // ****************************************
  // Static sideband levels
  // ****************************************
  // System-present asserts from the first edge after reset and never drops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adapter_system_present_n <= psb_pkg::PIN_NEGATE;
      map_enabled <= 1'b0;
      power_good_line <= 1'b0;
    end else begin
      adapter_system_present_n <= psb_pkg::PIN_ASSERT;
      map_enabled <= !map_enable_out_n;
      power_good_line <= line_power_low_n;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  localparam int TMO_BOUND = psb_pkg::TIMEOUT_CYC + 2;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_map_follows: assert property ($past(rst_n) |-> map_enabled == !$past(map_enable_out_n))
    else $error("map enable not followed");
  a_system_present: assert property ($past(rst_n) |-> !adapter_system_present_n)
    else $error("system present dropped");
  a_space_held: assert property ((state == psb_pkg::ST_SLV_WAIT) |-> !adapter_memory_space_n)
    else $error("space flag lost during claimed cycle");
  a_slave_timeout: assert property ($rose(state == psb_pkg::ST_SLV_WAIT) |-> ##[1:TMO_BOUND]
    (state != psb_pkg::ST_SLV_WAIT)) else $error("slave wait not bounded");
  a_grant_timeout: assert property ((state == psb_pkg::ST_INT_GRANT && tmr_expired && !bk_select_ack)
    |=> !adapter_timeout_n) else $error("grant timeout not flagged");
  a_busy_master: assert property ($rose(mst_granted) |-> $past(mst_request) && $past(interconnect_busy_in_n)
    && interconnect_busy_oe && !interconnect_busy_out_n) else $error("mastership taken while link busy");
  a_kind_steady: assert property (cycle_frame_oe && $past(cycle_frame_oe)
    |-> $stable(write_indicator_out_n) && $stable(byte_select_out_n)) else $error("cycle type moved mid cycle");
  a_reply_hold: assert property (reply_line_oe && !cycle_frame_in_n |=> reply_line_oe)
    else $error("reply dropped before frame end");
  a_byte_reply: assert property ((state == psb_pkg::ST_SLV_WAIT && bk_done
    && bk_kind == psb_pkg::CYC_BYTE_WRITE) |=> reply_line_oe) else $error("no reply to byte write");
  a_prio_capture: assert property ((state == psb_pkg::ST_IDLE && strobe_fall && !slave_take)
    |=> int_priority == $past(multiplexed_addr_data_in[psb_pkg::PRIO_W-1:0])) else $error("priority not taken");
  a_grant_answer: assert property ((state == psb_pkg::ST_INT_PRIO && !interrupt_ack_in_n)
    |=> bus_grant == psb_pkg::grant_for(int_priority)) else $error("grant does not match priority");
  a_power_follow: assert property ($past(rst_n) |-> power_good_line == $past(line_power_low_n))
    else $error("power good not following line power");
  a_frame_framing: assert property ((state == psb_pkg::ST_MST_OWN && mst_start)
    |=> cycle_frame_oe && !cycle_frame_out_n) else $error("frame not driven after start");

endmodule : psb_adapter_end

// ===== test/psb_cpu_model.sv
// Behavioural CPU end of the link sideband: map enable, frames, cycle type, interrupt grant.
// Assumes the bench calls its tasks just after a falling edge of clk_sys.
`timescale 1ns/1ps

module psb_cpu_model (
  input wire logic clk_sys,
  output logic map_enable_out_n,
  output logic frame_n,
  output logic wi_n,
  output logic bs_n,
  output logic busy_n,
  output logic [psb_pkg::ADDR_W-1:0] addr,
  output logic data_input_strobe_n,
  output logic interrupt_ack_in_n,
  input wire logic adapter_timeout_n
);
  // ****************************************
  // Pin drive
  // ****************************************
  logic [15:0] memory_mgmt_reg_three;
  logic [1:0] tmo_sync;

  // Timeout is retimed through two flops before the CPU end may act on it
  always @(posedge clk_sys) begin
    tmo_sync <= {tmo_sync[0], adapter_timeout_n};
  end

  // Released open-drain lines sit at the pull-up level
  initial begin
    memory_mgmt_reg_three = 16'h0000;
    frame_n = 1'b1;
    wi_n = 1'b1;
    bs_n = 1'b1;
    busy_n = 1'b1;
    addr = 16'h0000;
    data_input_strobe_n = 1'b1;
    interrupt_ack_in_n = 1'b1;
  end

  // Map enable follows bit 5 with no pipeline of its own
  assign map_enable_out_n = ~memory_mgmt_reg_three[5];

  task automatic set_map(input logic on);
    memory_mgmt_reg_three[5] = on;
  endtask : set_map

  // Every transfer speaks the link protocol, cycle type rides with the address
  task automatic put_addr(input logic [15:0] a, input logic [1:0] k);
    addr = a;
    wi_n = k[1];
    bs_n = k[0];
    busy_n = 1'b0;
  endtask : put_addr

  task automatic frame(input logic lvl);
    frame_n = lvl;
  endtask : frame

  // Inverted data on release, so a stale copy never passes for a hold
  task automatic release_bus();
    frame_n = 1'b1;
    wi_n = 1'b1;
    bs_n = 1'b1;
    busy_n = 1'b1;
    addr = ~addr;
  endtask : release_bus

  // Priority first, strobe later, then acknowledge; priority is pulled after the strobe
  task automatic int_grant(input logic [3:0] p);
    addr[3:0] = p;
    repeat (2) @(negedge clk_sys);
    data_input_strobe_n = 1'b0;
    @(negedge clk_sys);
    addr[3:0] = ~p;
    @(negedge clk_sys);
    interrupt_ack_in_n = 1'b0;
  endtask : int_grant

  // Also the reaction to a timeout: cancel the cycle and take the link back
  task automatic int_end();
    interrupt_ack_in_n = 1'b1;
    data_input_strobe_n = 1'b1;
    addr = ~addr;
  endtask : int_end

endmodule : psb_cpu_model

// ===== test/testbench.sv
// Self-checking bench for the adapter end of the link sideband.
// Assumes the CPU model drives the far side; open-drain wires resolve with pull-ups here.
`timescale 1ns/1ps

module testbench;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_sys, rst_n, lpl_n, bk_done, bk_select_ack, bk_vector_done;
  logic mst_request, mst_start, mst_end;
  psb_pkg::psb_cycle_e mst_kind, bk_kind;
  logic me_n, c_frame_n, c_wi_n, c_bs_n, c_busy_n, strobe_n, ack_n;
  logic [15:0] addr, bk_addr;
  logic fr_out_n, fr_oe, wi_out_n, wi_oe, bs_out_n, bs_oe, by_out_n, by_oe, rp_out_n, rp_oe;
  logic map_enabled, sys_n, mem_n, tmo_n, pgood, bk_req, mst_granted;
  logic [3:0] bus_grant, int_priority;
  int err_count, checks_done, cyc;

  // Wired-AND of both parties on each shared line
  wire logic frame_w = c_frame_n & (fr_oe ? fr_out_n : 1'b1);
  wire logic wi_w = c_wi_n & (wi_oe ? wi_out_n : 1'b1);
  wire logic bs_w = c_bs_n & (bs_oe ? bs_out_n : 1'b1);
  wire logic busy_w = c_busy_n & (by_oe ? by_out_n : 1'b1);

  psb_adapter_end u_psb_adapter_end (.clk_sys(clk_sys), .rst_n(rst_n), .map_enable_out_n(me_n),
    .cycle_frame_in_n(frame_w), .cycle_frame_out_n(fr_out_n), .cycle_frame_oe(fr_oe),
    .write_indicator_in_n(wi_w), .write_indicator_out_n(wi_out_n), .write_indicator_oe(wi_oe),
    .byte_select_in_n(bs_w), .byte_select_out_n(bs_out_n), .byte_select_oe(bs_oe),
    .interconnect_busy_in_n(busy_w), .interconnect_busy_out_n(by_out_n), .interconnect_busy_oe(by_oe),
    .reply_line_out_n(rp_out_n), .reply_line_oe(rp_oe), .multiplexed_addr_data_in(addr),
    .data_input_strobe_n(strobe_n), .interrupt_ack_in_n(ack_n), .line_power_low_n(lpl_n),
    .map_enabled(map_enabled), .adapter_system_present_n(sys_n), .adapter_memory_space_n(mem_n),
    .adapter_timeout_n(tmo_n), .power_good_line(pgood), .bus_grant(bus_grant),
    .int_priority(int_priority), .bk_req(bk_req), .bk_addr(bk_addr), .bk_kind(bk_kind),
    .bk_done(bk_done), .bk_select_ack(bk_select_ack), .bk_vector_done(bk_vector_done),
    .mst_request(mst_request), .mst_granted(mst_granted), .mst_start(mst_start),
    .mst_kind(mst_kind), .mst_end(mst_end));

  psb_cpu_model u_psb_cpu_model (.clk_sys(clk_sys), .map_enable_out_n(me_n), .frame_n(c_frame_n),
    .wi_n(c_wi_n), .bs_n(c_bs_n), .busy_n(c_busy_n), .addr(addr),
    .data_input_strobe_n(strobe_n), .interrupt_ack_in_n(ack_n), .adapter_timeout_n(tmo_n));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // All drives and samples happen at falling edges, clear of the sampling edge
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : step

  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_sideband();
    u_psb_cpu_model.set_map(1'b1);
    step(2);
    check(map_enabled, 1'b1);
    u_psb_cpu_model.set_map(1'b0);
    step(2);
    check(map_enabled, 1'b0);
    lpl_n = 1'b1;
    step(2);
    check(pgood, 1'b1);
    lpl_n = 1'b0;
    step(2);
    check(pgood, 1'b0);
    lpl_n = 1'b1;
  endtask : t_sideband

  // Adapter-space cycle answered by the backplane side
  task automatic t_slave(input logic [15:0] a, input logic [1:0] k);
    int i;
    u_psb_cpu_model.put_addr(a, k);
    step(1);
    check(mem_n, 1'b0);
    u_psb_cpu_model.frame(1'b0);
    for (i = 0; i < 4 && bk_req !== 1'b1; i++) step(1);
    check(bk_req, 1'b1);
    check(bk_addr, a);
    check(bk_kind, k);
    step(1);
    check(bk_req, 1'b0);
    check(mem_n, 1'b0);
    check(rp_oe, 1'b0);
    bk_done = 1'b1;
    step(1);
    bk_done = 1'b0;
    for (i = 0; i < 4 && rp_oe !== 1'b1; i++) step(1);
    check(rp_oe, 1'b1);
    check(rp_out_n, 1'b0);
    u_psb_cpu_model.release_bus();
    for (i = 0; i < 4 && rp_oe !== 1'b0; i++) step(1);
    check(rp_oe, 1'b0);
    step(1);
  endtask : t_slave

  // Just below adapter space: the adapter must stay out of the cycle
  task automatic t_local();
    int i;
    u_psb_cpu_model.put_addr(16'hBFFF, 2'h3);
    step(1);
    check(mem_n, 1'b1);
    u_psb_cpu_model.frame(1'b0);
    for (i = 0; i < 4; i++) begin
      step(1);
      check(bk_req | rp_oe, 1'b0);
    end
    u_psb_cpu_model.release_bus();
    step(2);
  endtask : t_local

  // No answer from the backplane: timeout at the fixed count, not before
  task automatic t_slave_tmo();
    int i;
    u_psb_cpu_model.put_addr(16'hC002, 2'h3);
    step(1);
    u_psb_cpu_model.frame(1'b0);
    step(240);
    check(tmo_n, 1'b1);
    for (i = 0; i < 30 && tmo_n !== 1'b0; i++) step(1);
    check(tmo_n, 1'b0);
    u_psb_cpu_model.release_bus();
    for (i = 0; i < 4 && tmo_n !== 1'b1; i++) step(1);
    check(tmo_n, 1'b1);
    step(2);
  endtask : t_slave_tmo

  // Interrupt grant; a priority without a grant line ends in a timeout
  task automatic t_int(input logic [3:0] p, input logic [3:0] g);
    int i;
    u_psb_cpu_model.int_grant(p);
    for (i = 0; i < 4 && bus_grant !== g; i++) step(1);
    check(int_priority, p);
    check(bus_grant, g);
    if (g != 4'h0) begin
      step(2);
      bk_select_ack = 1'b1;
      step(1);
      bk_select_ack = 1'b0;
      step(2);
      check(bus_grant, 4'h0);
      bk_vector_done = 1'b1;
      step(1);
      bk_vector_done = 1'b0;
      step(1);
      check(tmo_n, 1'b1);
      u_psb_cpu_model.int_end();
    end else begin
      step(240);
      check(tmo_n, 1'b1);
      for (i = 0; i < 30 && tmo_n !== 1'b0; i++) step(1);
      check(tmo_n, 1'b0);
      step(2);
      check(u_psb_cpu_model.tmo_sync[1], 1'b0);
      u_psb_cpu_model.int_end();
      for (i = 0; i < 4 && tmo_n !== 1'b1; i++) step(1);
      check(tmo_n, 1'b1);
    end
    step(2);
  endtask : t_int

  // Adapter takes the link and runs one cycle of every kind back to back
  task automatic t_master();
    int i;
    int k;
    check(mst_granted, 1'b0);
    mst_request = 1'b1;
    for (i = 0; i < 4 && mst_granted !== 1'b1; i++) step(1);
    check(mst_granted, 1'b1);
    check(busy_w, 1'b0);
    for (k = 0; k < 4; k++) begin
      mst_kind = psb_pkg::psb_cycle_e'(k[1:0]);
      mst_start = 1'b1;
      step(1);
      mst_start = 1'b0;
      for (i = 0; i < 4 && fr_oe !== 1'b1; i++) step(1);
      check(frame_w, 1'b0);
      check({wi_w, bs_w}, k[1:0]);
      mst_end = 1'b1;
      step(1);
      mst_end = 1'b0;
      for (i = 0; i < 4 && fr_oe !== 1'b0; i++) step(1);
      check(frame_w, 1'b1);
    end
    mst_request = 1'b0;
    for (i = 0; i < 4 && by_oe !== 1'b0; i++) step(1);
    check(busy_w, 1'b1);
    check(mst_granted, 1'b0);
    step(1);
  endtask : t_master

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Whole run is about 600 cycles; the ceiling leaves ample slack
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    rst_n = 1'b0;
    lpl_n = 1'b0;
    bk_done = 1'b0;
    bk_select_ack = 1'b0;
    bk_vector_done = 1'b0;
    mst_request = 1'b0;
    mst_start = 1'b0;
    mst_end = 1'b0;
    mst_kind = psb_pkg::CYC_READ;
    err_count = 0;
    checks_done = 0;
    cyc = 0;
    step(6);
    check(sys_n, 1'b1);
    check({fr_oe, wi_oe, bs_oe, by_oe, rp_oe, bk_req, mst_granted}, 7'h00);
    rst_n = 1'b1;
    step(2);
    check(sys_n, 1'b0);
    check(pgood, 1'b0);
    t_sideband();
    t_slave(16'hC000, 2'h3);
    t_slave(16'hFFFF, 2'h2);
    t_slave(16'hC0FE, 2'h1);
    t_slave(16'hD001, 2'h0);
    t_local();
    t_slave_tmo();
    t_int(4'h4, 4'h1);
    t_int(4'h7, 4'h8);
    t_int(4'h3, 4'h0);
    t_master();
    t_slave(16'hC004, 2'h0);
    tally_and_finish();
  end

endmodule : testbench
